// ==== src/bat_defs.svh ====
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef BAT_DEFS_SVH
`define BAT_DEFS_SVH

// ----------------------------------------------------------------------------
// I/O offsets (low eight address bits)
// ----------------------------------------------------------------------------
`define BAT_UPPER_BASE_OFS 8'h38
`define BAT_BANK_BASE_OFS 8'h39
`define BAT_AREA_BOUND_OFS 8'h3a

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define BAT_UPPER_START_MSB 7
`define BAT_UPPER_START_LSB 4
`define BAT_BANK_START_MSB 3
`define BAT_BANK_START_LSB 0
`define BAT_AREA_BOUND_RST 8'hf0
`define BAT_UPPER_BASE_RST 8'h00
`define BAT_BANK_BASE_RST 8'h00
`define BAT_PAGE_BITS 12
`define BAT_PADDR_RST 20'h00000
`define BAT_RDATA_RST 8'h00
`define BAT_UNMAPPED_RD 8'h00

`endif

// ==== src/bat_pkg.sv ====
package bat_pkg;

    typedef enum logic [1:0] {
        BAT_CYC_IDLE,
        BAT_CYC_MEM,
        BAT_CYC_IO,
        BAT_CYC_DMA
    } bat_cyc_t;

    typedef enum {
        BAT_REG_LOWER,
        BAT_REG_BANK,
        BAT_REG_UPPER
    } bat_region_t;

    // One bus cycle request from the core
    typedef struct packed {
        logic [1:0] kind;
        logic [15:0] laddr;
        logic [19:0] dma_addr;
    } bat_req_t;

    // I/O register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bat_io_t;

    typedef struct packed {
        logic [7:0] area_bound;
        logic [7:0] upper_base;
        logic [7:0] bank_base;
    } bat_regs_t;

endpackage : bat_pkg

// ==== src/bat_map.sv ====
`timescale 1ns/100ps
`include "bat_defs.svh"

// Pure combinational page mapper
module bat_map
    import bat_pkg::*;
(
    // Configuration
    input wire bat_regs_t regs_i,
    // Logical address in
    input wire logic [15:0] laddr_i,
    // Physical address out
    output logic [19:0] paddr_o
);

    logic [3:0] page;
    logic [3:0] upper_start;
    logic [3:0] bank_start;
    logic [7:0] base;
    logic [7:0] sum;

    assign page = laddr_i[15:12];
    assign upper_start = regs_i.area_bound[`BAT_UPPER_START_MSB:`BAT_UPPER_START_LSB];
    assign bank_start = regs_i.area_bound[`BAT_BANK_START_MSB:`BAT_BANK_START_LSB];

    always_comb
    begin
        if (page >= upper_start)
        begin
            base = regs_i.upper_base;
        end
        else if (page >= bank_start)
        begin
            base = regs_i.bank_base;
        end
        else
        begin
            base = 8'h00;
        end
        sum = base + {4'h0, page};
        paddr_o = {sum, laddr_i[`BAT_PAGE_BITS-1:0]};
    end

endmodule : bat_map

// ==== src/bat_top.sv ====
`timescale 1ns/100ps
`include "bat_defs.svh"

module bat_top
    import bat_pkg::*;
#(
    parameter int PADDR_W = 20
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Bus cycle from the core
    input wire bat_req_t req_i,
    // I/O register access
    input wire bat_io_t io_i,
    // Outputs
    output logic [19:0] paddr_o,
    output logic paddr_vld_o,
    output logic [7:0] rdata_o,
    output logic rdata_vld_o
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    // The mapper forms eight page bits beside a twelve-bit offset; any other
    // bus width would need a different adder and output stage
    if (PADDR_W != 20)
    begin : g_chk
        $error("bat_top serves only a 20-bit physical bus");
    end

    // Page compare and relocation both assume 4KB pages
    if (`BAT_PAGE_BITS != 12)
    begin : g_chk_page
        $error("bat_top serves only 4KB pages");
    end

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    // One-hot select: bit 2 area boundary, bit 1 upper base, bit 0 bank base.
    // The full low address byte is compared, so aliases are refused.
    function automatic logic [2:0] reg_sel(input logic [7:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        case (addr)
            `BAT_AREA_BOUND_OFS:
            begin
                sel = 3'h4;
            end
            `BAT_UPPER_BASE_OFS:
            begin
                sel = 3'h2;
            end
            `BAT_BANK_BASE_OFS:
            begin
                sel = 3'h1;
            end
            default:
            begin
                sel = 3'h0;
            end
        endcase
        return sel;
    endfunction : reg_sel

    // Read mux over the stored registers; unmapped offsets return a fixed value
    function automatic logic [7:0] reg_value(input logic [2:0] sel, input bat_regs_t regs);
        logic [7:0] val;
        val = `BAT_UNMAPPED_RD;
        if (sel[2])
        begin
            val = regs.area_bound;
        end
        else if (sel[1])
        begin
            val = regs.upper_base;
        end
        else if (sel[0])
        begin
            val = regs.bank_base;
        end
        return val;
    endfunction : reg_value

    logic [2:0] wr_sel;
    logic [2:0] rd_sel;

    assign wr_sel = io_i.wr ? reg_sel(io_i.addr) : 3'h0;
    assign rd_sel = reg_sel(io_i.addr);

    // ------------------------------------------------------------------------
    // Translation registers
    // ------------------------------------------------------------------------
    bat_regs_t regs_q;
    bat_regs_t regs_d;

    always_comb
    begin
        regs_d = regs_q;
        if (wr_sel[2])
        begin
            regs_d.area_bound = io_i.wdata;
        end
        if (wr_sel[1])
        begin
            regs_d.upper_base = io_i.wdata;
        end
        if (wr_sel[0])
        begin
            regs_d.bank_base = io_i.wdata;
        end
    end

    // A write lands at the edge that takes it; the mapper reads the stored
    // value, so a cycle taken at that same edge still sees the old map
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            regs_q.area_bound <= `BAT_AREA_BOUND_RST;
            regs_q.upper_base <= `BAT_UPPER_BASE_RST;
            regs_q.bank_base <= `BAT_BANK_BASE_RST;
        end
        else
        begin
            regs_q <= regs_d;
        end
    end

    // ------------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------------
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic rdata_vld_d;
    logic rdata_vld_q;

    // Data follows the addressed register every cycle; only the valid pulse
    // marks the cycle in which it answers a read
    always_comb
    begin
        rdata_d = reg_value(rd_sel, regs_q);
        rdata_vld_d = io_i.rd;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rdata_q <= `BAT_RDATA_RST;
            rdata_vld_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rdata_vld_q <= rdata_vld_d;
        end
    end

    // ------------------------------------------------------------------------
    // Address path
    // ------------------------------------------------------------------------
    logic [19:0] mapped;
    logic [19:0] paddr_d;
    logic [19:0] paddr_q;
    logic vld_d;
    logic vld_q;

    bat_map u_map (
        .regs_i(regs_q),
        .laddr_i(req_i.laddr),
        .paddr_o(mapped)
    );

    always_comb
    begin
        paddr_d = paddr_q;
        vld_d = 1'b1;
        case (bat_cyc_t'(req_i.kind))
            BAT_CYC_MEM:
            begin
                paddr_d = mapped;
            end
            BAT_CYC_IO:
            begin
                paddr_d = {4'h0, req_i.laddr};
            end
            BAT_CYC_DMA:
            begin
                paddr_d = req_i.dma_addr;
            end
            default:
            begin
                // Idle holds the bus, so the far side sees no stray change
                paddr_d = paddr_q;
                vld_d = 1'b0;
            end
        endcase
    end

    // Output registered for the flop-driven bus; the core presents the address
    // one cycle ahead so no wait state is added
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            paddr_q <= `BAT_PADDR_RST;
            vld_q <= 1'b0;
        end
        else
        begin
            paddr_q <= paddr_d;
            vld_q <= vld_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign paddr_o = paddr_q;
    assign paddr_vld_o = vld_q;
    assign rdata_o = rdata_q;
    assign rdata_vld_o = rdata_vld_q;

endmodule : bat_top

// ==== tb/bat_top_monitor.sv ====
`timescale 1ns/100ps
module bat_top_monitor
    import bat_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Requests
    input wire bat_req_t req_i,
    input wire bat_io_t io_i,
    // Results
    input wire logic [19:0] paddr_o,
    input wire logic paddr_vld_o,
    input wire logic [7:0] rdata_o,
    input wire logic rdata_vld_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    AST_VLD_ON: assert property (req_i.kind != 2'h0 |=> paddr_vld_o)
        else $error("valid missing");
    // Idle must neither flag nor move the bus
    AST_IDLE: assert property (req_i.kind == 2'h0 |=> !paddr_vld_o && $stable(paddr_o))
        else $error("idle moved");
    AST_IO: assert property (req_i.kind == 2'h2 |=> paddr_o == {4'h0, $past(req_i.laddr)})
        else $error("io altered");
    AST_DMA: assert property (req_i.kind == 2'h3 |=> paddr_o == $past(req_i.dma_addr))
        else $error("dma altered");
    AST_LOW: assert property (req_i.kind == 2'h1 |=> paddr_o[11:0] == $past(req_i.laddr[11:0]))
        else $error("offset altered");
    AST_RD_ON: assert property (io_i.rd |=> rdata_vld_o)
        else $error("read lost");
    AST_RD_OFF: assert property (!io_i.rd |=> !rdata_vld_o)
        else $error("stray read");
    AST_UNMAP: assert property (io_i.rd && !(io_i.addr inside {[8'h38:8'h3a]}) |=> rdata_o == 8'h00)
        else $error("unmapped data");
    cover property (req_i.kind == 2'h1 ##1 req_i.kind == 2'h1);
    cover property (io_i.wr && req_i.kind == 2'h1);
    cover property (req_i.kind == 2'h3);
endmodule : bat_top_monitor
bind bat_top bat_top_monitor u_mon (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
    .io_i(io_i), .paddr_o(paddr_o), .paddr_vld_o(paddr_vld_o), .rdata_o(rdata_o),
    .rdata_vld_o(rdata_vld_o));

// ==== tb/bat_cpu_model.sv ====
`timescale 1ns/100ps
module bat_cpu_model
    import bat_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Toward the translator
    output bat_req_t req_o = '0,
    output bat_io_t io_o = '0
);
    // One request per edge; the answer of the previous edge is settled on return
    task automatic cyc(input bat_req_t r, input bat_io_t i);
        @(posedge clk_i);
        req_o <= r;
        io_o <= i;
        #1;
    endtask : cyc
endmodule : bat_cpu_model

// ==== tb/bat_top_tb.sv ====
`timescale 1ns/100ps
module bat_top_tb;
    import bat_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    bat_req_t req;
    bat_io_t io;
    logic [19:0] paddr;
    logic [7:0] rdata;
    logic paddr_vld;
    logic rdata_vld;
    int err_count = 0;
    int compares = 0;
    always #12.5 clk_i = ~clk_i;
    bat_cpu_model cpu (.clk_i(clk_i), .req_o(req), .io_o(io));
    bat_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .io_i(io), .paddr_o(paddr),
        .paddr_vld_o(paddr_vld), .rdata_o(rdata), .rdata_vld_o(rdata_vld));
    task automatic cmp(input string n, input logic [19:0] e, input logic [19:0] s);
        compares++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask : cmp
    task automatic cmp_flag(input string n, input logic e, input logic s);
        compares++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch %s exp %b got %b", n, e, s);
        end
    endtask : cmp_flag
    // DMA field differs from the expectation unless DMA owns the bus
    task automatic m(input logic [1:0] k, input logic [15:0] a, input logic [19:0] e);
        cpu.cyc({k, a, (k == 2'h3) ? e : ~e}, '0);
        cpu.cyc('0, '0);
        cmp("paddr", e, paddr);
        cmp_flag("paddr_vld", 1'b1, paddr_vld);
    endtask : m
    task automatic r(input logic [7:0] a, input logic [7:0] e);
        cpu.cyc('0, {2'b01, a, 8'h00});
        cpu.cyc('0, '0);
        cmp("rdata", {12'h000, e}, {12'h000, rdata});
        cmp_flag("rdata_vld", 1'b1, rdata_vld);
        cmp_flag("paddr_vld", 1'b0, paddr_vld);
    endtask : r
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        cpu.cyc('0, {2'b10, a, d});
    endtask : w
    task automatic t_reset_state;
        r(8'h3a, 8'hf0);
        r(8'h38, 8'h00);
        r(8'h39, 8'h00);
        m(2'h1, 16'hffff, 20'h0ffff);
        m(2'h1, 16'h0123, 20'h00123);
    endtask : t_reset_state
    task automatic t_regions;
        w(8'h3a, 8'h84);
        w(8'h38, 8'h20);
        w(8'h39, 8'h10);
        m(2'h1, 16'h3fff, 20'h03fff);
        m(2'h1, 16'h4000, 20'h14000);
        m(2'h1, 16'h7fff, 20'h17fff);
        m(2'h1, 16'h8abc, 20'h28abc);
        r(8'h39, 8'h10);
        r(8'h3a, 8'h84);
        r(8'h38, 8'h20);
    endtask : t_regions
    task automatic t_write_timing;
        cpu.cyc({2'h1, 16'h4000, 20'h0}, {2'b10, 8'h39, 8'h30});
        cpu.cyc({2'h1, 16'h4001, 20'h0}, '0);
        cmp("paddr", 20'h14000, paddr);
        cmp_flag("paddr_vld", 1'b1, paddr_vld);
        cpu.cyc('0, '0);
        cmp("paddr", 20'h34001, paddr);
        cmp_flag("paddr_vld", 1'b1, paddr_vld);
    endtask : t_write_timing
    task automatic t_overlap;
        w(8'h38, 8'h0c);
        w(8'h39, 8'h10);
        m(2'h1, 16'h4123, 20'h14123);
        m(2'h1, 16'h8123, 20'h14123);
        m(2'h1, 16'h7fff, 20'h17fff);
        m(2'h1, 16'h8000, 20'h14000);
        w(8'h38, 8'hf7);
        m(2'h1, 16'h8fff, 20'hfffff);
        w(8'h38, 8'hf0);
        m(2'h1, 16'hfa5a, 20'hffa5a);
        m(2'h1, 16'hc5a5, 20'hfc5a5);
        w(8'h3a, 8'h88);
        m(2'h1, 16'h7abc, 20'h07abc);
        m(2'h1, 16'h8abc, 20'hf8abc);
    endtask : t_overlap
    task automatic t_bypass;
        m(2'h2, 16'hfedc, 20'h0fedc);
        m(2'h3, 16'h1234, 20'h9abcd);
    endtask : t_bypass
    task automatic t_unmapped;
        r(8'h3b, 8'h00);
        w(8'h3b, 8'h55);
        r(8'h3b, 8'h00);
        r(8'h3a, 8'h88);
        r(8'h38, 8'hf0);
        r(8'h39, 8'h10);
    endtask : t_unmapped
    task automatic t_mid_reset;
        cpu.cyc('0, '0);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        cmp("paddr", 20'h00000, paddr);
        cmp_flag("paddr_vld", 1'b0, paddr_vld);
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset_state;
    endtask : t_mid_reset
    task automatic print_verdict;
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial
    begin
        #20us;
        err_count++;
        print_verdict;
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset_state;
        t_regions;
        t_write_timing;
        t_overlap;
        t_bypass;
        t_unmapped;
        t_mid_reset;
        print_verdict;
    end
endmodule : bat_top_tb
